//--- common/cmp_pkg.sv
// types shared by the motor pwm block
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package cmp_pkg;

  // counting alignment field, values 0..3 in declaration order
  typedef enum logic [1:0] {ALIGN_EDGE, ALIGN_CENTER1, ALIGN_CENTER2, ALIGN_CENTER3} cmp_align_type;

  // control bits software owns (output enable lives apart, hardware clears it)
  typedef struct packed {
    logic          auto_out_en;
    logic          brk_pol;
    logic          brk_en;
    cmp_align_type align;
    logic          counter_run_enable;
  } cmp_ctrl_type;

  // one register write as the bus slave delivers it
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } cmp_wr_type;

endpackage
`default_nettype wire

//--- common/cmp_regs.svh
// register offsets, field positions, reset values for the motor pwm block
// assumes a 32-bit axi4-lite slave with an 8-bit byte address
//
// Contract
// - center modes count up then down alternately; edge mode counts up only
// - alignment field 00 selects edge-aligned counting
// - field 01 flags compares only counting down; 10 only counting up
// - field 11 flags compares in both counting directions
// - counting up: channel 1 inactive below compare, active otherwise
// - counting down: channel 1 active above compare, inactive otherwise
// - break enabled with polarity; no automatic output re-enable after break
// - idle levels for high and low outputs, then outputs enabled
// - inverted overcurrent comparator drives break input; low forces outputs off
// - channel four compare event triggers current-sampling converter, rising edge
`ifndef CMP_REGS_SVH
`define CMP_REGS_SVH

`define CMP_OFF_CTRL      8'h00
`define CMP_OFF_PERIOD    8'h04
`define CMP_OFF_CMP1      8'h08
`define CMP_OFF_DEAD      8'h18
`define CMP_OFF_REP       8'h1C
`define CMP_OFF_IDLE      8'h20
`define CMP_OFF_STATUS    8'h24
`define CMP_OFF_MASK      8'h28
`define CMP_OFF_COUNT     8'h2C

`define CMP_CTRL_MOE_BIT  3
`define CMP_ST_UPD_BIT    0
`define CMP_ST_CC1_BIT    1
`define CMP_ST_BRK_BIT    5
`define CMP_ST_W          6

`define CMP_RESP_OKAY     2'h0
`define CMP_RESP_SLVERR   2'h2
`define CMP_PERIOD_RST    16'hFFFF
`define CMP_DEAD_RST      8'h10

`endif

//--- design/cmp_axil_slave.sv
// axi4-lite slave front end: turns bus transfers into single-cycle register writes/reads
// assumes the register file answers rd_data/rd_hit combinationally from rd_addr
`include "cmp_regs.svh"
`default_nettype none
module cmp_axil_slave
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  output var  cmp_pkg::cmp_wr_type wr,
  output var  logic              wr_fire,
  input  wire logic              wr_hit,
  output var  logic [7:0]        rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_hit
);
  import cmp_pkg::*;

  logic       aw_got_reg;
  logic       w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       have_aw;
  logic       have_w;
  logic       aw_got_next;
  logic       w_got_next;
  logic       bvalid_next;
  logic       rvalid_next;

  // handshakes; address and data may arrive in either order
  always_comb
  begin
    aw_hs       = awvalid && awready;
    w_hs        = wvalid && wready;
    ar_hs       = arvalid && arready;
    have_aw     = aw_got_reg || aw_hs;
    have_w      = w_got_reg || w_hs;
    wr_fire     = have_aw && have_w;
    aw_got_next = have_aw && !wr_fire;
    w_got_next  = have_w && !wr_fire;
    bvalid_next = wr_fire || (bvalid && !bready);
    rvalid_next = ar_hs || (rvalid && !rready);
    wr.addr     = aw_hs ? awaddr : aw_addr_reg;
    wr.data     = w_hs ? wdata : w_data_reg;
    wr.strb     = w_hs ? wstrb : w_strb_reg;
    rd_addr     = araddr;
  end

  // write channel state; readies registered so they come from flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      awready     <= 1'b0;
      wready      <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= `CMP_RESP_OKAY;
    end
    else
    begin
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      if (aw_hs)
        aw_addr_reg <= awaddr;
      if (w_hs)
      begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      awready <= !aw_got_next && !bvalid_next;
      wready  <= !w_got_next && !bvalid_next;
      bvalid  <= bvalid_next;
      if (wr_fire)
        bresp <= wr_hit ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
    end
  end

  // read channel: one read outstanding, data captured at address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `CMP_RESP_OKAY;
    end
    else
    begin
      arready <= !rvalid_next;
      rvalid  <= rvalid_next;
      if (ar_hs)
      begin
        rdata <= rd_hit ? rd_data : 32'h0;
        rresp <= rd_hit ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
      end
    end
  end

endmodule // cmp_axil_slave
`default_nettype wire

//--- design/cmp_dead_time.sv
// dead-time generator for one complementary pair
// assumes ref_in is a registered or stable level in the aclk domain
`default_nettype none
module cmp_dead_time
#(
  parameter int DT_W = 8
)
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            ref_in,
  input  wire logic [DT_W-1:0] dead,
  output var  logic            high_out,
  output var  logic            low_out
);
  import cmp_pkg::*;

  logic            prev_reg;
  logic [DT_W-1:0] cnt_reg;

  // any edge of the reference drops both sides, then waits dead cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_reg <= 1'b0;
      cnt_reg  <= '0;
      high_out <= 1'b0;
      low_out  <= 1'b0;
    end
    else
    begin
      prev_reg <= ref_in;
      if (ref_in != prev_reg)
      begin
        cnt_reg  <= dead;
        high_out <= 1'b0;
        low_out  <= 1'b0;
      end
      else if (cnt_reg != '0)
        cnt_reg <= cnt_reg - 1'b1;
      else
      begin
        high_out <= ref_in;
        low_out  <= !ref_in;
      end
    end
  end

  AST_DT_NO_OVERLAP: assert property (@(posedge aclk) disable iff (!aresetn) !(high_out && low_out))
    else $error("both switches of a pair active together");

endmodule // cmp_dead_time
`default_nettype wire

//--- design/cmp_pwm_top.sv
// three-phase center-aligned pwm generator with break, dead time and adc trigger
// assumes an axi4-lite master on aclk and a gate driver on the pwm pins
`include "cmp_regs.svh"
`default_nettype none
module cmp_pwm_top
#(
  parameter int CNT_W  = 16,
  parameter int PHASES = 3,
  parameter int DT_W   = 8,
  parameter int REP_W  = 8
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  input  wire logic              overcurrent_comparator,
  output var  logic [PHASES-1:0] pwm_high,
  output var  logic [PHASES-1:0] pwm_low,
  output var  logic              adc_trigger,
  output var  logic              irq
);
  import cmp_pkg::*;

  localparam int NCH = 4;

  cmp_wr_type              wr;
  logic                    wr_fire;
  logic                    wr_hit;
  logic [7:0]              rd_addr;
  logic [31:0]             rd_data;
  logic                    rd_hit;
  cmp_ctrl_type            ctrl_reg;
  logic                    moe_reg;
  logic [CNT_W-1:0]        period_reg;
  logic [CNT_W-1:0]        cmp_pre_reg [NCH];
  logic [CNT_W-1:0]        cmp_act_reg [NCH];
  logic [DT_W-1:0]         dead_reg;
  logic [REP_W-1:0]        rep_reg;
  logic [REP_W-1:0]        rep_cnt_reg;
  logic [2*PHASES-1:0]     idle_reg;
  logic [`CMP_ST_W-1:0]    status_reg;
  logic [`CMP_ST_W-1:0]    mask_reg;
  logic [`CMP_ST_W-1:0]    status_next;
  logic [CNT_W-1:0]        cnt_reg;
  logic                    dir_down_reg;
  logic                    run;
  logic                    wrap;
  logic                    upd;
  logic                    break_input;
  logic                    brk_evt;
  logic                    ctrl_wr;
  logic [31:0]             ctrl_merged;
  logic                    out_en;
  logic [NCH-1:0]          cc_evt;
  logic [PHASES-1:0]       pwm_ref;
  logic [PHASES-1:0]       dt_high;
  logic [PHASES-1:0]       dt_low;

  // byte-lane merge of a bus write into an existing word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = data[8*b +: 8];
    return res;
  endfunction

  // may a compare match raise its flag in this alignment and direction
  function automatic logic cc_allowed(input cmp_align_type align, input logic down);
    logic ok;
    unique case (align)
      ALIGN_EDGE:    ok = 1'b1;
      ALIGN_CENTER1: ok = down;
      ALIGN_CENTER2: ok = !down;
      ALIGN_CENTER3: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // byte address of compare register n
  function automatic logic [7:0] cmp_addr(input int n);
    return 8'(`CMP_OFF_CMP1 + 4 * n);
  endfunction

  cmp_axil_slave u_bus
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr      (wr),
    .wr_fire (wr_fire),
    .wr_hit  (wr_hit),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_hit  (rd_hit)
  );

  // break, period wrap, update event and compare events
  always_comb
  begin
    run         = ctrl_reg.counter_run_enable;
    break_input = !overcurrent_comparator;
    brk_evt     = ctrl_reg.brk_en && (break_input == ctrl_reg.brk_pol);
    ctrl_wr     = wr_fire && wr.addr == `CMP_OFF_CTRL;
    ctrl_merged = wmerge({25'h0, ctrl_reg[5:3], moe_reg, ctrl_reg[2:0]}, wr.data, wr.strb); // moe sits at bit 3
    out_en      = moe_reg && !brk_evt;
    if (ctrl_reg.align == ALIGN_EDGE)
      wrap = run && cnt_reg >= period_reg;
    else
      wrap = run && (dir_down_reg ? cnt_reg == '0 : cnt_reg >= period_reg);
    upd = wrap && rep_cnt_reg == '0;
    for (int i = 0; i < NCH; i++)
      cc_evt[i] = run && cnt_reg == cmp_act_reg[i] && cc_allowed(ctrl_reg.align, dir_down_reg);
    // up: below compare is inactive; down: above compare is active
    for (int p = 0; p < PHASES; p++)
      pwm_ref[p] = dir_down_reg ? (cnt_reg > cmp_act_reg[p])
                                : !(cnt_reg < cmp_act_reg[p]);
  end

  // up/down counter; a stopped counter holds its value and direction
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg      <= '0;
      dir_down_reg <= 1'b0;
    end
    else if (run)
    begin
      if (ctrl_reg.align == ALIGN_EDGE)
      begin
        dir_down_reg <= 1'b0;
        cnt_reg      <= (cnt_reg >= period_reg) ? '0 : cnt_reg + 1'b1;
      end
      else if (!dir_down_reg)
      begin
        if (cnt_reg >= period_reg)
        begin
          dir_down_reg <= 1'b1;
          if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
      else if (cnt_reg == '0)
      begin
        dir_down_reg <= 1'b0;
        cnt_reg      <= cnt_reg + 1'b1;
      end
      else
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // repetition counter and compare shadow load; while running, duty only changes at update
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rep_cnt_reg <= '0;
      for (int i = 0; i < NCH; i++)
        cmp_act_reg[i] <= '0;
    end
    else
    begin
      if (!run)
        rep_cnt_reg <= rep_reg;
      else if (wrap)
        rep_cnt_reg <= (rep_cnt_reg == '0) ? rep_reg : rep_cnt_reg - 1'b1;
      // stopped counter loads directly so the first period starts right
      if (upd || !run)
        for (int i = 0; i < NCH; i++)
          cmp_act_reg[i] <= cmp_pre_reg[i];
    end
  end

  // software register writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg   <= '0;
      period_reg <= `CMP_PERIOD_RST;
      dead_reg   <= `CMP_DEAD_RST;
      rep_reg    <= '0;
      idle_reg   <= '0;
      mask_reg   <= '0;
      for (int i = 0; i < NCH; i++)
        cmp_pre_reg[i] <= '0;
    end
    else if (wr_fire)
    begin
      unique case (wr.addr)
        // alignment is expected to change only while stopped
        `CMP_OFF_CTRL:   ctrl_reg   <= cmp_ctrl_type'({ctrl_merged[6:4], ctrl_merged[2:0]});
        `CMP_OFF_PERIOD: period_reg <= CNT_W'(wmerge(32'(period_reg), wr.data, wr.strb));
        `CMP_OFF_DEAD:   dead_reg   <= DT_W'(wmerge(32'(dead_reg), wr.data, wr.strb));
        `CMP_OFF_REP:    rep_reg    <= REP_W'(wmerge(32'(rep_reg), wr.data, wr.strb));
        `CMP_OFF_IDLE:   idle_reg   <= (2*PHASES)'(wmerge(32'(idle_reg), wr.data, wr.strb));
        `CMP_OFF_MASK:   mask_reg   <= `CMP_ST_W'(wmerge(32'(mask_reg), wr.data, wr.strb));
        default:
        begin
          for (int i = 0; i < NCH; i++)
            if (wr.addr == cmp_addr(i))
              cmp_pre_reg[i] <= CNT_W'(wmerge(32'(cmp_pre_reg[i]), wr.data, wr.strb));
        end
      endcase
    end
  end

  // main output enable: break clears it and wins over software and update
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      moe_reg <= 1'b0;
    else if (brk_evt)
      moe_reg <= 1'b0;
    else if (ctrl_wr && wr.strb[0])
      moe_reg <= wr.data[`CMP_CTRL_MOE_BIT];
    else if (upd && ctrl_reg.auto_out_en)
      moe_reg <= 1'b1;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_comb
  begin
    status_next = status_reg;
    if (wr_fire && wr.addr == `CMP_OFF_STATUS && wr.strb[0])
      status_next = status_next & ~wr.data[`CMP_ST_W-1:0];
    status_next[`CMP_ST_UPD_BIT] = status_next[`CMP_ST_UPD_BIT] | upd;
    status_next[`CMP_ST_CC1_BIT +: NCH] = status_next[`CMP_ST_CC1_BIT +: NCH] | cc_evt;
    status_next[`CMP_ST_BRK_BIT] = status_next[`CMP_ST_BRK_BIT] | brk_evt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_reg  <= '0;
      irq         <= 1'b0;
      adc_trigger <= 1'b0;
    end
    else
    begin
      status_reg  <= status_next;
      irq         <= |(status_next & mask_reg);
      adc_trigger <= cc_evt[3];
    end
  end

  // dead-time pair per phase
  for (genvar p = 0; p < PHASES; p++)
  begin : g_phase
    cmp_dead_time #(.DT_W(DT_W)) u_dt
    (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ref_in   (pwm_ref[p]),
      .dead     (dead_reg),
      .high_out (dt_high[p]),
      .low_out  (dt_low[p])
    );
  end

  // pins: pwm pairs while enabled, programmed idle levels otherwise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_high <= '0;
      pwm_low  <= '0;
    end
    else
    begin
      pwm_high <= out_en ? dt_high : idle_reg[PHASES-1:0];
      pwm_low  <= out_en ? dt_low : idle_reg[2*PHASES-1:PHASES];
    end
  end

  // read mux; count register shows live counter and direction
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_data = 32'h0;
    unique case (rd_addr)
      `CMP_OFF_CTRL:   rd_data = {25'h0, ctrl_reg[5:3], moe_reg, ctrl_reg[2:0]};
      `CMP_OFF_PERIOD: rd_data = 32'(period_reg);
      `CMP_OFF_DEAD:   rd_data = 32'(dead_reg);
      `CMP_OFF_REP:    rd_data = 32'(rep_reg);
      `CMP_OFF_IDLE:   rd_data = 32'(idle_reg);
      `CMP_OFF_STATUS: rd_data = 32'(status_reg);
      `CMP_OFF_MASK:   rd_data = 32'(mask_reg);
      `CMP_OFF_COUNT:  rd_data = {15'h0, dir_down_reg, 16'(cnt_reg)};
      default:
      begin
        rd_hit = 1'b0;
        for (int i = 0; i < NCH; i++)
          if (rd_addr == cmp_addr(i))
          begin
            rd_hit  = 1'b1;
            rd_data = 32'(cmp_pre_reg[i]);
          end
      end
    endcase
    wr_hit = 1'b1;
    if (wr.addr > `CMP_OFF_MASK || wr.addr[1:0] != 2'h0)
      wr_hit = 1'b0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_EDGE_UP_ONLY: assert property (run && ctrl_reg.align == ALIGN_EDGE |=> !dir_down_reg)
    else $error("edge mode counted down");
  AST_CENTER_TURN: assert property (run && ctrl_reg.align != ALIGN_EDGE && !dir_down_reg && cnt_reg >= period_reg
                                    && period_reg != '0 && $stable(ctrl_reg) |=> dir_down_reg)
    else $error("center mode did not reverse at the top");
  AST_EDGE_FLAG: assert property (run && ctrl_reg.align == ALIGN_EDGE && cnt_reg == cmp_act_reg[0]
                                  |=> status_reg[`CMP_ST_CC1_BIT])
    else $error("edge mode match did not set flag");
  AST_C1_DOWN_ONLY: assert property ($rose(status_reg[`CMP_ST_CC1_BIT]) && $past(ctrl_reg.align) == ALIGN_CENTER1
                                     |-> $past(dir_down_reg))
    else $error("variant one flagged while counting up");
  AST_C2_UP_ONLY: assert property ($rose(status_reg[`CMP_ST_CC1_BIT]) && $past(ctrl_reg.align) == ALIGN_CENTER2
                                   |-> !$past(dir_down_reg))
    else $error("variant two flagged while counting down");
  AST_C3_BOTH: assert property (run && ctrl_reg.align == ALIGN_CENTER3 && cnt_reg == cmp_act_reg[0]
                                |=> status_reg[`CMP_ST_CC1_BIT])
    else $error("variant three match did not set flag");
  AST_REF_UP: assert property (!dir_down_reg |-> pwm_ref[0] == (cnt_reg >= cmp_act_reg[0]))
    else $error("channel one wrong while counting up");
  AST_REF_DOWN: assert property (dir_down_reg |-> pwm_ref[0] == (cnt_reg > cmp_act_reg[0]))
    else $error("channel one wrong while counting down");
  AST_BREAK_IDLE: assert property (brk_evt |=> !moe_reg && pwm_high == idle_reg[PHASES-1:0]
                                   && pwm_low == idle_reg[2*PHASES-1:PHASES])
    else $error("break did not force idle levels");
  AST_NO_AUTO_ON: assert property (!moe_reg && !ctrl_reg.auto_out_en && !ctrl_wr |=> !moe_reg)
    else $error("outputs re-enabled without software");
  AST_ADC_TRIG: assert property (run && cnt_reg == cmp_act_reg[3] && cc_allowed(ctrl_reg.align, dir_down_reg)
                                 |=> adc_trigger ##1 !adc_trigger)
    else $error("converter trigger missing or too long");
  AST_SHADOW: assert property (run && !upd |=> cmp_act_reg[0] == $past(cmp_act_reg[0]))
    else $error("compare value changed outside update");

endmodule // cmp_pwm_top
`default_nettype wire

//--- test/center_aligned_motor_pwm_tb.sv
// bench for the pwm block: count modes, flags, pins, interrupt, break
// assumes cmp_pwm_top and cmp_gate_model compiled before it
`include "cmp_regs.svh"
`default_nettype none
module center_aligned_motor_pwm_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, trip = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, adc_trigger, irq, overcurrent_comparator;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, bs, rs;
  logic [2:0]  pwm_high, pwm_low, hi, lo;
  int          bad_count = 0, tests_run = 0, shoot_cnt, adc_cnt = 0, a0;
  always #10 aclk = ~aclk;
  // converter trigger pulses, one per high cycle
  always @(posedge aclk) if (adc_trigger) adc_cnt <= adc_cnt + 1;
  cmp_pwm_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .overcurrent_comparator(overcurrent_comparator),
    .pwm_high(pwm_high), .pwm_low(pwm_low), .adc_trigger(adc_trigger), .irq(irq));
  cmp_gate_model u_gate (.aclk(aclk), .trip(trip), .pwm_high(pwm_high), .pwm_low(pwm_low),
    .overcurrent_comparator(overcurrent_comparator), .shoot_cnt(shoot_cnt));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // expected channel 1 level from a frozen count word
  function automatic logic ref_exp(input logic [31:0] c);
    return c[16] ? c[15:0] > 16'h0014 : c[15:0] >= 16'h0014;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // stop near 28 counting up, then near 9 counting down in center modes; flags gated by mode
  task automatic mode_run(input logic [1:0] m);
    rst();
    wr(`CMP_OFF_PERIOD, 32'h3C);
    wr(`CMP_OFF_CMP1, 32'h14);
    wr(`CMP_OFF_MASK, 32'h2);
    for (int ph = 0; ph < 2; ph++)
    begin
      a0 = adc_cnt;
      wr(`CMP_OFF_CTRL, {28'h0, 1'b1, m, 1'b1});
      repeat (ph ? 80 : 25) @(posedge aclk);
      wr(`CMP_OFF_CTRL, {28'h0, 1'b1, m, 1'b0});
      rdr(`CMP_OFF_STATUS);
      chk("cc1_flag", rd[1], ph ? m != 2'h2 : m != 2'h1);
      chk("irq_set", irq, ph ? m != 2'h2 : m != 2'h1);
      wr(`CMP_OFF_STATUS, 32'h3F);
      chk("irq_clr", irq, 1'b0);
      rdr(`CMP_OFF_COUNT);
      chk("count_dir", rd[16], ph && m != 2'h0);
      repeat (25) @(posedge aclk); // dead time 16 settles
      chk("pwm_high0", pwm_high[0], ref_exp(rd));
      chk("pwm_low0", pwm_low[0], !ref_exp(rd));
      // channel four compare sits at 0: hit at start or at the edge-mode wrap
      chk("adc_pulses", adc_cnt - a0, ph ? m == 2'h0 : m != 2'h1);
    end
    $display("test mode %0d done", m);
  endtask
  initial
  begin
    void'($urandom(1641));
    rst();
    rdr(`CMP_OFF_PERIOD);
    chk("period_rst", rd, 32'hFFFF);
    rdr(`CMP_OFF_DEAD);
    chk("dead_rst", rd, 32'h10);
    rdr(8'h30);
    chk("unmapped_rd", rd, 32'h0);
    chk("unmapped_rresp", 32'(rs), 32'h2);
    wr(8'h30, 32'h1);
    chk("unmapped_wr", bs, 2'h2);
    $display("test registers done");
    for (int m = 0; m < 4; m++) mode_run(2'(m));
    // break with each polarity; auto output enable left off
    for (int p = 0; p < 2; p++)
    begin
      rst();
      hi = 3'($urandom);
      lo = ~hi & 3'($urandom);
      wr(`CMP_OFF_IDLE, {26'h0, lo, hi});
      wr(`CMP_OFF_PERIOD, 32'h3C);
      wr(`CMP_OFF_REP, 32'h1);
      wr(`CMP_OFF_CTRL, {25'h0, 1'b0, p[0], 4'hD, 1'b1});
      trip <= !p[0];
      repeat (5) @(posedge aclk);
      trip <= p[0];
      repeat (300) @(posedge aclk);
      chk("idle_pins", {pwm_low, pwm_high}, {lo, hi});
      rdr(`CMP_OFF_CTRL);
      chk("moe_stays_off", rd[3], 1'b0);
      rdr(`CMP_OFF_STATUS);
      chk("brk_flag", rd[5], 1'b1);
      trip <= 1'b0;
      $display("test break pol %0d done", p);
    end
    chk("shoot_through", 32'(shoot_cnt), 32'h0);
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    report_and_stop();
  end
endmodule // center_aligned_motor_pwm_tb
`default_nettype wire

//--- test/cmp_gate_model.sv
// gate driver stand-in: trips the overcurrent comparator on command
// assumes pwm pins are active-high levels on aclk
`default_nettype none
module cmp_gate_model
(
  input  wire logic       aclk,
  input  wire logic       trip,
  input  wire logic [2:0] pwm_high,
  input  wire logic [2:0] pwm_low,
  output var  logic       overcurrent_comparator,
  output var  int         shoot_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  initial overcurrent_comparator = 1'b0;
  initial shoot_cnt = 0;
  // comparator high on overcurrent; the block inverts it into break
  always @(posedge aclk) overcurrent_comparator <= trip;
  // both switches of one leg on would short the bus
  always @(posedge aclk) if (|(pwm_high & pwm_low)) shoot_cnt <= shoot_cnt + 1;
endmodule // cmp_gate_model
`default_nettype wire
